// ===== adsps_pkg.sv
// Constants shared by the two-axis stop and position-sync command logic.
// Assumes a single 10 MHz system clock; no timescale needed here.
package adsps_pkg;

    // Clock and time base for deceleration times, counted in milliseconds
    localparam int CLK_HZ         = 10_000_000;
    localparam int DECEL_UNIT_US  = 1000;
    localparam int TICK_CYC_DEF   = (CLK_HZ / 1_000_000) * DECEL_UNIT_US;

    // Operand ranges
    localparam logic [15:0] AXIS_COUNT   = 16'h0002;
    localparam logic [15:0] STEP_MAX_STD = 16'h001E;
    localparam logic [15:0] STEP_MAX_ADV = 16'h0050;

    // Error codes reported by the position-synchronous start
    localparam logic [15:0] ERR_NONE        = 16'h0000;
    localparam logic [15:0] ERR_AUX_ORIGIN  = 16'h0158;
    localparam logic [15:0] ERR_MAIN_ORIGIN = 16'h015A;
    localparam logic [15:0] ERR_SAME_AXIS   = 16'h015B;

    // Reset values
    localparam logic [7:0]  STEP_RST = 8'h00;
    localparam logic [31:0] POS_RST  = 32'h0000_0000;

    // Per-axis motion state
    typedef enum logic [2:0] {
        AX_IDLE  = 3'b001,
        AX_RUN   = 3'b010,
        AX_DECEL = 3'b100
    } adsps_ax_state_t;

endpackage

// ===== adsps_axis.sv
// One axis of pulse output: runs to an absolute goal, can be halted at once
// or ramped down. Assumes start/stop are one-cycle pulses on the same clock.
`timescale 1ns/1ps
`default_nettype none
module adsps_axis
    import adsps_pkg::*;
(
    input  wire logic               clock,
    input  wire logic               rst,
    input  wire logic               ce,
    input  wire logic               ms_tick,
    input  wire logic               start,
    input  wire logic               stop,
    input  wire logic               mcode_en,
    input  wire logic signed [31:0] target,
    input  wire logic        [15:0] period,
    input  wire logic        [15:0] stop_ms,
    output logic                    pulse,
    output logic                    dir,
    output logic                    busy,
    output logic                    done,
    output logic                    mcode,
    output logic signed      [31:0] pos
);

    adsps_ax_state_t  state;
    logic signed [31:0] goal;
    logic        [23:0] gap_cnt;
    logic        [23:0] extra;
    logic        [15:0] ms_left;
    logic               at_goal;
    logic               hard_stop;
    logic               moving;

    assign at_goal   = (pos == goal);
    assign hard_stop = stop && (stop_ms == 16'h0000);
    assign moving    = (state != AX_IDLE) && !at_goal && !hard_stop;

    // Motion sequencing; a start while moving is ignored
    always_ff @(posedge clock) begin
        if (rst) begin
            state <= AX_IDLE;
            busy  <= 1'b0;
        end else if (ce) begin
            unique case (state)
                AX_IDLE: begin
                    if (start && (target != pos)) begin
                        state <= AX_RUN;
                        busy  <= 1'b1;
                    end
                end
                AX_RUN: begin
                    if (hard_stop || at_goal) begin
                        state <= AX_IDLE;
                        busy  <= 1'b0;
                    end else if (stop) begin
                        state <= AX_DECEL;
                    end
                end
                AX_DECEL: begin
                    // Ramp ends when its time runs out or the goal is hit
                    if (at_goal || hard_stop || (ms_left == 16'h0000)) begin
                        state <= AX_IDLE;
                        busy  <= 1'b0;
                    end
                end
            endcase
        end
    end

    // Goal and direction are latched at start only
    always_ff @(posedge clock) begin
        if (rst) begin
            goal <= POS_RST;
            dir  <= 1'b0;
        end else if (ce && start && (state == AX_IDLE)) begin
            goal <= target;
            dir  <= (target > pos);
        end
    end

    // Deceleration timer and growing pulse gap
    always_ff @(posedge clock) begin
        if (rst) begin
            ms_left <= 16'h0000;
            extra   <= 24'h000000;
        end else if (ce) begin
            if (state == AX_RUN && stop) begin
                ms_left <= stop_ms;
                extra   <= 24'h000000;
            end else if (state == AX_DECEL && ms_tick && |ms_left) begin
                ms_left <= ms_left - 16'h0001;
                // Linear stretch; cheaper than a true divide-based profile
                extra   <= extra + 24'(period[15:3]) + 24'h000001;
            end
        end
    end

    // Pulse generation and position tracking
    always_ff @(posedge clock) begin
        if (rst) begin
            pulse   <= 1'b0;
            gap_cnt <= 24'h000000;
            pos     <= POS_RST;
        end else if (ce) begin
            pulse <= 1'b0;
            if (!moving) begin
                gap_cnt <= 24'h000000;
            end else if (gap_cnt + 24'h000001 >= {8'h00, period} + extra) begin
                gap_cnt <= 24'h000000;
                pulse   <= 1'b1;
                pos     <= dir ? pos + 32'sd1 : pos - 32'sd1;
            end else begin
                gap_cnt <= gap_cnt + 24'h000001;
            end
        end
    end

    // Completion is only reported when the goal is reached in a normal run
    always_ff @(posedge clock) begin
        if (rst) begin
            done  <= 1'b0;
            mcode <= 1'b0;
        end else if (ce) begin
            if (start && (state == AX_IDLE)) begin
                done  <= 1'b0;
                mcode <= 1'b0;
            end else if (state == AX_RUN && at_goal && !stop) begin
                done  <= 1'b1;
                mcode <= mcode_en;
            end
        end
    end

endmodule
`default_nettype wire

// ===== adsps_top.sv
// Command front end for two pulse-output axes: deceleration stop and
// main-axis position-synchronous start. Commands come from controller
// logic on the same clock; step data is looked up outside by cur_step.
//
// Notes on behaviour
// - Stop edge ramps the chosen axis down over the deceleration time.
// - Axis selector must be 0 or 1; otherwise error flag set, nothing done.
// - Zero deceleration time operand halts pulses at once, no ramp.
// - Nonzero time: direct profile if directly started, else step one.
// - A stopped axis sets neither positioning done nor output-code flag.
// - Stop leaves the current step number unchanged for later restart.
// - Absolute step restart outputs only the pulses left to the target.
// - Incremental step restart moves full distance again from stop point.
// - Aux axis starts when main axis position reaches programmed value.
// - Trigger position is a full-range signed 32-bit value.
// - Auxiliary step must be 0..30 standard or 0..80 advanced.
// - Main axis selector of sync start must be 0 or 1.
// - Accepted sync start: aux axis busy, no pulses, until trigger hit.
// - Missing origin rejects sync start: 346 main axis, 344 auxiliary.
// - Same axis as main and auxiliary rejects sync start with code 347.
`timescale 1ns/1ps
`default_nettype none
module adsps_top
    import adsps_pkg::*;
#(
    parameter int TICK_CYCLES = TICK_CYC_DEF
)
(
    input  wire logic                    clock,
    input  wire logic                    rst,
    input  wire logic                    ce,
    input  wire logic                    decel_stop_cmd,
    input  wire logic                    pos_sync_start_cmd,
    input  wire logic              [1:0] indirect_start_cmd,
    input  wire logic              [1:0] direct_start_cmd,
    input  wire logic             [15:0] slot_operand,
    input  wire logic             [15:0] axis_select_operand,
    input  wire logic             [31:0] first_param_operand,
    input  wire logic             [15:0] aux_step_operand,
    input  wire logic             [15:0] main_axis_operand,
    input  wire logic                    advanced_mode,
    input  wire logic              [1:0] origin_fixed,
    input  wire logic       [1:0][31:0] step_target_pos,
    input  wire logic              [1:0] step_incremental,
    input  wire logic       [1:0][15:0] step_decel_ms,
    input  wire logic              [1:0] step_mcode_en,
    input  wire logic       [1:0][31:0] direct_target_pos,
    input  wire logic       [1:0][15:0] direct_decel_ms,
    input  wire logic       [1:0][15:0] pulse_period,
    output logic                   [1:0] pulse_out,
    output logic                   [1:0] dir_out,
    output logic                   [1:0] mcode_flag,
    output logic                         axis0_busy_flag,
    output logic                         axis1_busy_flag,
    output logic                         axis0_pos_done_flag,
    output logic                         axis1_pos_done_flag,
    output logic                         instr_error_flag,
    output logic                  [15:0] sync_error_code,
    output logic            [1:0][7:0] cur_step,
    output logic           [1:0][31:0] cur_pos
);

    localparam logic [15:0] TICK_LAST = 16'(TICK_CYCLES - 1);

    logic        stop_q;
    logic        sync_q;
    logic  [1:0] ist_q;
    logic  [1:0] dst_q;
    logic        stop_edge;
    logic        sync_edge;
    logic  [1:0] ist_edge;
    logic  [1:0] dst_edge;
    logic        ax_ok;
    logic        main_ok;
    logic        step_ok;
    logic        ax_idx;
    logic        main_idx;
    logic        sync_go;
    logic [15:0] next_sync_code;
    logic [15:0] tick_cnt;
    logic        ms_tick;
    logic  [1:0] armed;
    logic  [1:0] direct_mode;
    logic  [1:0] ax_busy;
    logic  [1:0] ax_done;
    logic [1:0][31:0] armed_pos;

    // Previous command levels; holding a command high does nothing more
    always_ff @(posedge clock) begin
        if (rst) begin
            stop_q <= 1'b0;
            sync_q <= 1'b0;
            ist_q  <= 2'h0;
            dst_q  <= 2'h0;
        end else if (ce) begin
            stop_q <= decel_stop_cmd;
            sync_q <= pos_sync_start_cmd;
            ist_q  <= indirect_start_cmd;
            dst_q  <= direct_start_cmd;
        end
    end

    assign stop_edge = decel_stop_cmd & ~stop_q;
    assign sync_edge = pos_sync_start_cmd & ~sync_q;
    assign ist_edge  = indirect_start_cmd & ~ist_q;
    assign dst_edge  = direct_start_cmd & ~dst_q;

    // Operand checks; the slot operand is ignored, only one engine exists
    assign ax_ok    = (axis_select_operand < AXIS_COUNT);
    assign main_ok  = (main_axis_operand < AXIS_COUNT);
    assign step_ok  = (aux_step_operand <=
                       (advanced_mode ? STEP_MAX_ADV : STEP_MAX_STD));
    assign ax_idx   = axis_select_operand[0];
    assign main_idx = main_axis_operand[0];

    // Sync start refusals in order of precedence
    always_comb begin
        next_sync_code = ERR_NONE;
        if (ax_idx == main_idx) begin
            next_sync_code = ERR_SAME_AXIS;
        end else if (!origin_fixed[main_idx]) begin
            next_sync_code = ERR_MAIN_ORIGIN;
        end else if (!origin_fixed[ax_idx]) begin
            next_sync_code = ERR_AUX_ORIGIN;
        end
    end

    // Stop wins when both commands rise in the same cycle
    assign sync_go = sync_edge && !stop_edge && ax_ok && main_ok && step_ok &&
                     (next_sync_code == ERR_NONE);

    // Error flag shows the outcome of the latest stop or sync command
    always_ff @(posedge clock) begin
        if (rst) begin
            instr_error_flag <= 1'b0;
            sync_error_code  <= ERR_NONE;
        end else if (ce) begin
            if (stop_edge) begin
                instr_error_flag <= !ax_ok;
            end else if (sync_edge) begin
                instr_error_flag <= !(ax_ok && main_ok && step_ok);
                if (ax_ok && main_ok && step_ok) begin
                    sync_error_code <= next_sync_code;
                end
            end
        end
    end

    // Millisecond time base for deceleration ramps
    always_ff @(posedge clock) begin
        if (rst) begin
            tick_cnt <= 16'h0000;
            ms_tick  <= 1'b0;
        end else if (ce) begin
            ms_tick <= (tick_cnt == TICK_LAST);
            if (tick_cnt == TICK_LAST) begin
                tick_cnt <= 16'h0000;
            end else begin
                tick_cnt <= tick_cnt + 16'h0001;
            end
        end
    end

    // Busy shows motion or a pending synchronous start
    always_ff @(posedge clock) begin
        if (rst) begin
            axis0_busy_flag <= 1'b0;
            axis1_busy_flag <= 1'b0;
        end else if (ce) begin
            axis0_busy_flag <= ax_busy[0] | armed[0];
            axis1_busy_flag <= ax_busy[1] | armed[1];
        end
    end

    assign axis0_pos_done_flag = ax_done[0];
    assign axis1_pos_done_flag = ax_done[1];

    for (genvar g = 0; g < 2; g++) begin : g_axis
        logic               stop_me;
        logic               trig;
        logic               start_me;
        logic        [15:0] stop_ms;
        logic signed [31:0] goal;

        assign stop_me = stop_edge && ax_ok && (ax_idx == 1'(g));
        // Main axis is always the other axis once accepted
        assign trig = armed[g] &&
                      (cur_pos[1 - g] == armed_pos[g]);
        assign start_me = trig ||
                          ((ist_edge[g] || dst_edge[g]) && !armed[g]);

        // Nonzero time operand only selects ramping; duration is the profile
        always_comb begin
            stop_ms = 16'h0000;
            if (first_param_operand[15:0] != 16'h0000) begin
                stop_ms = direct_mode[g] ? direct_decel_ms[g]
                                         : step_decel_ms[g];
            end
        end

        // Absolute steps aim at the stored target; incremental add distance
        always_comb begin
            if (dst_edge[g] && !trig) begin
                goal = direct_target_pos[g];
            end else if (step_incremental[g]) begin
                goal = cur_pos[g] + step_target_pos[g];
            end else begin
                goal = step_target_pos[g];
            end
        end

        // Step number changes only when a sync start names a new one
        always_ff @(posedge clock) begin
            if (rst) begin
                cur_step[g]    <= STEP_RST;
                direct_mode[g] <= 1'b0;
            end else if (ce) begin
                if (sync_go && ax_idx == 1'(g)) begin
                    cur_step[g] <= aux_step_operand[7:0];
                end
                if (start_me && !ax_busy[g]) begin
                    direct_mode[g] <= dst_edge[g] && !trig;
                end
            end
        end

        // Arming holds the aux axis until the main axis reaches the value
        always_ff @(posedge clock) begin
            if (rst) begin
                armed[g]     <= 1'b0;
                armed_pos[g] <= POS_RST;
            end else if (ce) begin
                if (stop_me || trig) begin
                    armed[g] <= 1'b0;
                end else if (sync_go && ax_idx == 1'(g)) begin
                    armed[g]     <= 1'b1;
                    armed_pos[g] <= first_param_operand;
                end
            end
        end

        adsps_axis u_axis (
            .clock    (clock),
            .rst      (rst),
            .ce       (ce),
            .ms_tick  (ms_tick),
            .start    (start_me),
            .stop     (stop_me),
            .mcode_en (step_mcode_en[g] && !(dst_edge[g] && !trig)),
            .target   (goal),
            .period   (pulse_period[g]),
            .stop_ms  (stop_ms),
            .pulse    (pulse_out[g]),
            .dir      (dir_out[g]),
            .busy     (ax_busy[g]),
            .done     (ax_done[g]),
            .mcode    (mcode_flag[g]),
            .pos      (cur_pos[g])
        );
    end

endmodule
`default_nettype wire

// ===== adsps_monitor.sv
// Checker for the stop and position-sync command front end.
// Bound onto adsps_top; sees only its ports, one clock, ce held high.
`timescale 1ns/1ps
`default_nettype none
module adsps_monitor
    import adsps_pkg::*;
(
    input  wire logic        clock,
    input  wire logic        rst,
    input  wire logic        ce,
    input  wire logic        decel_stop_cmd,
    input  wire logic        pos_sync_start_cmd,
    input  wire logic [15:0] axis_select_operand,
    input  wire logic [31:0] first_param_operand,
    input  wire logic [15:0] aux_step_operand,
    input  wire logic [15:0] main_axis_operand,
    input  wire logic        advanced_mode,
    input  wire logic  [1:0] origin_fixed,
    input  wire logic  [1:0] pulse_out,
    input  wire logic        axis0_busy_flag,
    input  wire logic        axis1_busy_flag,
    input  wire logic        axis0_pos_done_flag,
    input  wire logic        instr_error_flag,
    input  wire logic [15:0] sync_error_code
);
    logic        stop_q;
    logic        sync_q;
    logic        stop_rise;
    logic        sync_go;
    logic [15:0] smax;
    logic        ops_ok;

    // Command levels one cycle back, as the design keeps them
    always_ff @(posedge clock) begin
        if (rst) begin
            stop_q <= 1'b0;
            sync_q <= 1'b0;
        end else if (ce) begin
            stop_q <= decel_stop_cmd;
            sync_q <= pos_sync_start_cmd;
        end
    end

    // A sync edge together with a stop edge is dropped by the design
    assign stop_rise = ce & decel_stop_cmd & ~stop_q;
    assign sync_go   = ce & pos_sync_start_cmd & ~sync_q & ~stop_rise;
    assign smax      = advanced_mode ? STEP_MAX_ADV : STEP_MAX_STD;
    assign ops_ok    = (axis_select_operand < AXIS_COUNT) &&
                       (main_axis_operand < AXIS_COUNT) &&
                       (aux_step_operand <= smax);

    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    a_stop_bad_sel:
    assert property (stop_rise && axis_select_operand > 16'h0001
        |=> instr_error_flag) else $error("bad stop axis not flagged");
    a_sync_bad_main:
    assert property (sync_go && main_axis_operand > 16'h0001
        |=> instr_error_flag) else $error("bad main axis not flagged");
    a_sync_bad_step:
    assert property (sync_go && aux_step_operand > smax
        |=> instr_error_flag) else $error("bad step not flagged");
    a_same_axis_code:
    assert property (sync_go && ops_ok &&
        axis_select_operand == main_axis_operand
        |=> sync_error_code == ERR_SAME_AXIS && !instr_error_flag)
        else $error("same axis code wrong");
    a_main_origin_code:
    assert property (sync_go && ops_ok &&
        axis_select_operand != main_axis_operand &&
        !origin_fixed[main_axis_operand[0]] &&
        origin_fixed[axis_select_operand[0]]
        |=> sync_error_code == ERR_MAIN_ORIGIN)
        else $error("main origin code wrong");
    a_aux_origin_code:
    assert property (sync_go && ops_ok &&
        axis_select_operand != main_axis_operand &&
        origin_fixed[main_axis_operand[0]] &&
        !origin_fixed[axis_select_operand[0]]
        |=> sync_error_code == ERR_AUX_ORIGIN)
        else $error("aux origin code wrong");
    a_zero_time_halt:
    assert property (stop_rise && axis_select_operand == 16'h0000 &&
        first_param_operand[15:0] == 16'h0000
        |-> ##2 (!pulse_out[0]) [*3]) else $error("pulses after halt");
    a_stop_no_done:
    assert property (stop_rise && axis_select_operand == 16'h0000 &&
        axis0_busy_flag |=> (!axis0_pos_done_flag) [*4])
        else $error("done raised after stop");
    a_armed_busy:
    assert property (sync_go && ops_ok && axis_select_operand == 16'h0001
        && main_axis_operand == 16'h0000 && origin_fixed == 2'h3
        |-> ##2 axis1_busy_flag && !pulse_out[1])
        else $error("armed axis not waiting busy");
endmodule
`default_nettype wire

// ===== adsps_drive.sv
// Pulse-train motor drive model: counts pulses per axis in the set direction.
// Assumes pulse_out and dir_out change together on the system clock.
`timescale 1ns/1ps
`default_nettype none
module adsps_drive (
    input  wire logic        clock,
    input  wire logic        rst,
    input  wire logic  [1:0] pulse_out,
    input  wire logic  [1:0] dir_out,
    output logic [1:0][31:0] drive_pos
);
    // Shaft position as the drive sees it; wraps like the signed counter
    always_ff @(posedge clock) begin
        for (int a = 0; a < 2; a++) begin
            if (rst)
                drive_pos[a] <= 32'h0000_0000;
            else if (pulse_out[a])
                drive_pos[a] <= dir_out[a] ? drive_pos[a] + 32'h0000_0001
                                           : drive_pos[a] - 32'h0000_0001;
        end
    end
endmodule
`default_nettype wire

// ===== adsps_top_test.sv
// Self-checking bench for adsps_top with a drive model on the pulse side.
// Assumes adsps_monitor and adsps_drive are compiled first.
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin error_cnt++; \
    $display("FAIL t=%0t got %0h exp %0h", $time, (g), (e)); end end
module adsps_top_test
    import adsps_pkg::*;
;
    typedef struct packed {
        logic        sync;
        logic [15:0] sel;
        logic [15:0] stepn;
        logic [15:0] mainsel;
        logic        adv;
        logic  [1:0] org;
        logic        err;
        logic [15:0] code;
    } adsps_row_t;
    logic              clock, rst, ce, decel_stop_cmd, pos_sync_start_cmd;
    logic        [1:0] indirect_start_cmd, direct_start_cmd, origin_fixed;
    logic       [15:0] slot_operand, axis_select_operand, aux_step_operand;
    logic       [15:0] main_axis_operand;
    logic       [31:0] first_param_operand, p, q;
    logic              advanced_mode, axis0_busy_flag, axis1_busy_flag;
    logic              axis0_pos_done_flag, axis1_pos_done_flag;
    logic              instr_error_flag;
    logic        [1:0] step_incremental, step_mcode_en, pulse_out, dir_out;
    logic        [1:0] mcode_flag;
    logic  [1:0][31:0] step_target_pos, direct_target_pos, cur_pos, drive_pos;
    logic  [1:0][15:0] step_decel_ms, direct_decel_ms, pulse_period;
    logic       [15:0] sync_error_code;
    logic   [1:0][7:0] cur_step;
    logic signed [31:0] m;
    int                n, error_cnt, checked;
    // Operand ranges with one accepted stop on axis 1, then the three sync codes
    adsps_row_t rows [10] = '{
        '{1'b0, 16'h0002, 16'h0000, 16'h0000, 1'b0, 2'h3, 1'b1, ERR_NONE},
        '{1'b0, 16'hFFFF, 16'h0000, 16'h0000, 1'b0, 2'h3, 1'b1, ERR_NONE},
        '{1'b0, 16'h0001, 16'h0000, 16'h0000, 1'b0, 2'h3, 1'b0, ERR_NONE},
        '{1'b1, 16'h0001, 16'h0001, 16'h0002, 1'b0, 2'h3, 1'b1, ERR_NONE},
        '{1'b1, 16'h0002, 16'h0001, 16'h0000, 1'b0, 2'h3, 1'b1, ERR_NONE},
        '{1'b1, 16'h0001, 16'h001F, 16'h0000, 1'b0, 2'h3, 1'b1, ERR_NONE},
        '{1'b1, 16'h0001, 16'h0051, 16'h0000, 1'b1, 2'h3, 1'b1, ERR_NONE},
        '{1'b1, 16'h0001, 16'h0050, 16'h0001, 1'b1, 2'h3, 1'b0,
          ERR_SAME_AXIS},
        '{1'b1, 16'h0001, 16'h0001, 16'h0000, 1'b0, 2'h2, 1'b0,
          ERR_MAIN_ORIGIN},
        '{1'b1, 16'h0001, 16'h0001, 16'h0000, 1'b0, 2'h1, 1'b0,
          ERR_AUX_ORIGIN}};

    // Short ms base keeps ramps to tens of cycles
    adsps_top #(.TICK_CYCLES(10)) dut_u (.*);
    adsps_drive drv_u (.*);

    initial begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end

    task tick(input int k);
        repeat (k) @(posedge clock);
        #10;
    endtask
    // Each command is one rising edge, dropped again before returning
    task do_stop(input logic [15:0] s, input logic [15:0] t);
        axis_select_operand = s;
        first_param_operand = {16'h0000, t};
        decel_stop_cmd = 1'b1;
        tick(1);
        decel_stop_cmd = 1'b0;
        tick(1);
    endtask
    task do_sync(input logic [15:0] s, input logic [15:0] st,
                 input logic [15:0] mn, input logic [31:0] trg);
        axis_select_operand = s;
        aux_step_operand = st;
        main_axis_operand = mn;
        first_param_operand = trg;
        pos_sync_start_cmd = 1'b1;
        tick(1);
        pos_sync_start_cmd = 1'b0;
        tick(1);
    endtask
    task go(input logic d, input int a);
        if (d)
            direct_start_cmd[a] = 1'b1;
        else
            indirect_start_cmd[a] = 1'b1;
        tick(1);
        direct_start_cmd = 2'h0;
        indirect_start_cmd = 2'h0;
        tick(1);
    endtask
    task close_out;
        if (error_cnt == 0 && checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // Run takes about 600 cycles; this cuts off a hang
    initial begin
        repeat (6000) @(posedge clock);
        error_cnt++;
        close_out();
    end

    initial begin
        {rst, ce, decel_stop_cmd, pos_sync_start_cmd} = 4'hC;
        {indirect_start_cmd, direct_start_cmd} = 4'h0;
        slot_operand = 16'h0000;
        {axis_select_operand, aux_step_operand} = 32'h0;
        {main_axis_operand, first_param_operand} = 48'h0;
        {advanced_mode, origin_fixed} = 3'h3;
        {step_target_pos, direct_target_pos} = 128'h0;
        {step_incremental, step_mcode_en} = 4'h3;
        {step_decel_ms, direct_decel_ms} = 64'h0006_0006_0003_0003;
        pulse_period = {2{16'h0002}};
        tick(4);
        rst = 1'b0;
        tick(1);
        `CHK(cur_pos, 64'h0)
        `CHK({axis0_busy_flag, axis0_pos_done_flag, instr_error_flag}, 3'h0)
        for (int i = 0; i < 10; i++) begin
            advanced_mode = rows[i].adv;
            origin_fixed = rows[i].org;
            if (rows[i].sync)
                do_sync(rows[i].sel, rows[i].stepn, rows[i].mainsel, 32'h0);
            else
                do_stop(rows[i].sel, 16'h0000);
            `CHK(instr_error_flag, rows[i].err)
            if (rows[i].sync && !rows[i].err)
                `CHK(sync_error_code, rows[i].code)
        end
        {advanced_mode, origin_fixed} = 3'h3;
        // Immediate halt, then a ramped stop on a direct run
        direct_target_pos[0] = 32'h0000_00C8;
        go(1'b1, 0);
        tick(20);
        do_stop(16'h0000, 16'h0000);
        tick(3);
        p = cur_pos[0];
        tick(6);
        `CHK(cur_pos[0], p)
        `CHK({axis0_busy_flag, axis0_pos_done_flag}, 2'h0)
        go(1'b1, 0);
        tick(10);
        do_stop(16'h0000, 16'h0005);
        q = cur_pos[0];
        for (n = 0; n < 200 && axis0_busy_flag !== 1'b0; n++) tick(1);
        `CHK(cur_pos[0] > q, 1'b1)
        `CHK(n >= 15 && n <= 40, 1'b1)
        `CHK(axis0_pos_done_flag, 1'b0)
        // Absolute step interrupted, then resumed to its own goal
        step_target_pos[0] = 32'h0000_0040;
        go(1'b0, 0);
        tick(16);
        do_stop(16'h0000, 16'h0000);
        tick(4);
        `CHK(mcode_flag[0], 1'b0)
        `CHK(cur_step[0], STEP_RST)
        go(1'b0, 0);
        for (n = 0; n < 400 && axis0_pos_done_flag !== 1'b1; n++) tick(1);
        `CHK(drive_pos[0], 32'h0000_0040)
        `CHK(mcode_flag[0], 1'b1)
        // Incremental resume with the start input held far past the move
        {step_incremental[0], step_mcode_en} = 3'h4;
        step_target_pos[0] = 32'h0000_0014;
        go(1'b0, 0);
        tick(10);
        do_stop(16'h0000, 16'h0000);
        tick(3);
        p = drive_pos[0];
        indirect_start_cmd[0] = 1'b1;
        tick(120);
        indirect_start_cmd[0] = 1'b0;
        `CHK(drive_pos[0], p + 32'h0000_0014)
        `CHK(axis0_pos_done_flag, 1'b1)
        // Axis 1 waits for axis 0 to pass a negative trigger
        step_target_pos[1] = 32'h0000_000F;
        step_incremental[1] = 1'b0;
        do_sync(16'h0001, 16'h0005, 16'h0000, 32'hFFFF_FFFB);
        tick(5);
        `CHK({axis1_busy_flag, pulse_out[1]}, 2'h2)
        `CHK(drive_pos[1], 32'h0)
        `CHK(cur_step[1], 8'h05)
        direct_target_pos[0] = 32'hFFFF_FFE2;
        go(1'b1, 0);
        for (n = 0; n < 600 && drive_pos[1] === 32'h0; n++) tick(1);
        m = cur_pos[0];
        `CHK(m <= -32'sh5 && m >= -32'sh8, 1'b1)
        for (n = 0; n < 200 && axis1_pos_done_flag !== 1'b1; n++) tick(1);
        `CHK(drive_pos[1], 32'h0000_000F)
        close_out();
    end
endmodule

bind adsps_top adsps_monitor mon_u (
    .clock, .rst, .ce, .decel_stop_cmd, .pos_sync_start_cmd,
    .axis_select_operand, .first_param_operand, .aux_step_operand,
    .main_axis_operand, .advanced_mode, .origin_fixed, .pulse_out,
    .axis0_busy_flag, .axis1_busy_flag, .axis0_pos_done_flag,
    .instr_error_flag, .sync_error_code
);
`default_nettype wire
